//--- mbx_pkg.sv
`default_nettype none
package mbx_pkg;
  localparam int CSR_W     = 32;
  localparam int ALLOW_BIT = 0;
  localparam int PEND_BIT  = 1;
  localparam int RING_BIT  = 2;
  localparam int READY_BIT = 3;
  localparam int RESET_BIT = 4;
  localparam int OVF_BIT   = 5;
  localparam int USED_LSB  = 8;
  localparam int USED_W    = 4;
  localparam int DEPTH_LSB = 24;
  localparam int DEPTH_W   = 8;
  localparam int CB_DEPTH  = 8;
  localparam int CB_AW     = 3;
  localparam int CNT_W     = 4;
  localparam logic [DEPTH_W-1:0] DEPTH_RST = 8'h08;
  localparam logic [1:0]         PS_D0     = 2'h0;
  localparam logic [1:0]         PS_D3     = 2'h3;

  typedef logic [CSR_W-1:0]   word_t;
  typedef logic [DEPTH_W-1:0] depth_t;

  function automatic logic one_hot(input depth_t v);
    return (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
  endfunction

  function automatic word_t pack_csr(input logic allow, input logic pend, input logic ring,
                                     input logic rdy, input logic rst, input logic ovf,
                                     input logic [USED_W-1:0] used, input depth_t depth);
    word_t w;
    w = '0;
    w[ALLOW_BIT] = allow;
    w[PEND_BIT]  = pend;
    w[RING_BIT]  = ring;
    w[READY_BIT] = rdy;
    w[RESET_BIT] = rst;
    w[OVF_BIT]   = ovf;
    w[USED_LSB +: USED_W]   = used;
    w[DEPTH_LSB +: DEPTH_W] = depth;
    return w;
  endfunction
endpackage
`default_nettype wire

//--- db_if.sv
`timescale 1ns/10ps
`default_nettype none
interface db_if;
  logic ring;
  logic clr;
  logic allow;
  logic pending;
  logic irq;
  modport core (input ring, input clr, input allow, output pending, output irq);
  modport ctrl (output ring, output clr, output allow, input pending, input irq);
endinterface
`default_nettype wire

//--- mbx_doorbell.sv
`timescale 1ns/10ps
`default_nettype none
module mbx_doorbell (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  db_if.core        db
);
  logic pend_q;
  logic pend_d;
  logic irq_q;
  logic irq_d;

  always_comb
  begin
    // A ring in the same cycle as a write-one clear keeps the bit set
    pend_d = db.ring | (pend_q & ~db.clr);
    irq_d  = pend_q & db.allow;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_q <= 1'h0;
      irq_q  <= 1'h0;
    end
    else if (ce)
    begin
      pend_q <= pend_d;
      irq_q  <= irq_d;
    end
  end

  assign db.pending = pend_q;
  assign db.irq     = irq_q;
endmodule
`default_nettype wire

//--- mbx_cbuf.sv
`timescale 1ns/10ps
`default_nettype none
module mbx_cbuf (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  input  wire logic                     clear,
  input  wire logic                     wr,
  input  wire mbx_pkg::word_t           wdata,
  input  wire logic                     rd,
  output var  mbx_pkg::word_t           rdata,
  output var  logic [mbx_pkg::CNT_W-1:0] used,
  output var  logic                     overflow
);
  mbx_pkg::word_t                mem_q [mbx_pkg::CB_DEPTH];
  mbx_pkg::word_t                mem_d [mbx_pkg::CB_DEPTH];
  logic [mbx_pkg::CB_AW-1:0]     wptr_q, wptr_d, rptr_q, rptr_d;
  logic [mbx_pkg::CNT_W-1:0]     cnt_q, cnt_d;
  logic                          ovf_q, ovf_d;
  mbx_pkg::word_t                rdata_q, rdata_d;
  logic                          full, do_wr, do_rd;
  mbx_pkg::word_t                head;

  assign full  = (cnt_q == mbx_pkg::CNT_W'(mbx_pkg::CB_DEPTH));
  assign do_wr = wr & ~full & ~clear;
  assign do_rd = rd & (cnt_q != 4'h0) & ~clear;
  assign head  = mem_q[rptr_q];

  always_comb
  begin
    mem_d   = mem_q;
    wptr_d  = wptr_q;
    rptr_d  = rptr_q;
    ovf_d   = ovf_q | (wr & full & ~clear);
    rdata_d = rdata_q;
    if (do_wr)
    begin
      mem_d[wptr_q] = wdata;
      wptr_d        = wptr_q + mbx_pkg::CB_AW'(1);
    end
    if (do_rd)
    begin
      rdata_d = head; // see R7
      rptr_d  = rptr_q + mbx_pkg::CB_AW'(1);
    end
    cnt_d = cnt_q + mbx_pkg::CNT_W'(do_wr) - mbx_pkg::CNT_W'(do_rd);
    if (clear)
    begin
      wptr_d = '0;
      rptr_d = '0;
      cnt_d  = '0;
      ovf_d  = 1'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < mbx_pkg::CB_DEPTH; i++)
        mem_q[i] <= '0;
      wptr_q  <= '0;
      rptr_q  <= '0;
      cnt_q   <= '0;
      ovf_q   <= 1'h0;
      rdata_q <= '0;
    end
    else if (ce)
    begin
      mem_q   <= mem_d;
      wptr_q  <= wptr_d;
      rptr_q  <= rptr_d;
      cnt_q   <= cnt_d;
      ovf_q   <= ovf_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata    = rdata_q;
  assign used     = cnt_q;
  assign overflow = ovf_q;

  read_window_a: assert property (@(posedge clk) disable iff (!rst_n || !ce) // see R7
    do_rd |=> (rdata_q == $past(head)))
    else $error("read window did not return the oldest dword");
endmodule
`default_nettype wire

//--- host_mgmt_mailbox_link.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// R1: A firmware doorbell ring sets the host pending bit, interrupts the host only if allowed, then self-clears.
// R2: Writing one to the pending position of the host control word clears the host pending bit.
// R3: The host handler reads the host control word and writes it back to acknowledge the pending bit.
// R4: A firmware alive bit seen as zero makes the host start an interface reset and leave its handler. The host model only leaves its handler.
// R5: An empty firmware buffer on an interrupt tells the host its own sent slots are free again.
// R6: A firmware buffer overflow makes the host re-enter its interface initialisation flow. The host model only leaves its handler.
// R7: Each host read of the firmware read window returns the next dword, once per filled slot.
// R8: After draining, the host rings its doorbell while keeping its other control bits.
// R9: The host link is ready only with memory decode on, power state zero, base set, no host reset, both alive.
// R10: The firmware link is ready only with a one-hot depth field, no firmware reset and both sides alive.
// R11: The host rings its doorbell whenever it changes reset or ready or finishes a read or write. Code rings only on a ring-bit write.
// R12: The firmware doorbell rings whenever firmware changes reset or alive or finishes a read or write.
// R13: While the link is ready an overflow of either buffer resets the interface.
// R14: While the link is ready the host dropping its ready bit resets the interface.
// R15: One interrupt line per side covers all four causes and the handler tells them apart from state.
// R16: Only the D0 and D3 power states are accepted.
// R17: The host interrupt output is a level held while pending and allow are both set.
module host_mgmt_mailbox_link (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      ce,
  input  wire logic                      host_csr_wr,
  input  wire mbx_pkg::word_t            host_csr_wdata,
  output var  mbx_pkg::word_t            host_side_ctrl_status,
  input  wire logic                      fw_csr_wr,
  input  wire mbx_pkg::word_t            fw_csr_wdata,
  output var  mbx_pkg::word_t            fw_side_ctrl_status,
  input  wire logic                      mem_space_en,
  input  wire logic [1:0]                power_state,
  input  wire logic                      bar_assigned,
  input  wire logic                      host_cb_wr,
  input  wire mbx_pkg::word_t            host_cb_wdata,
  input  wire logic                      fw_cb_rd,
  output var  mbx_pkg::word_t            fw_cb_rdata,
  input  wire logic                      fw_cb_wr,
  input  wire mbx_pkg::word_t            fw_cb_wdata,
  input  wire logic                      fw_window_rd,
  output var  mbx_pkg::word_t            fw_buffer_read_window,
  output var  logic [mbx_pkg::CNT_W-1:0] fw_buffer_used_slots,
  input  wire logic                      fw_read_done,
  input  wire logic                      fw_write_done,
  output var  mbx_pkg::word_t            fw_status_host_view,
  output var  logic                      fw_alive_host_view,
  output var  logic                      host_irq,
  output var  logic                      fw_irq,
  output var  logic                      host_link_ready,
  output var  logic                      fw_link_ready,
  output var  logic                      pm_in_d3
);
  logic                      rst_meta_q;
  logic                      rst_q;
  logic                      h_allow_q, h_allow_d;
  logic                      h_ready_q, h_ready_d;
  logic                      h_reset_q, h_reset_d;
  logic                      host_doorbell_ring_q, host_doorbell_ring_d;
  logic                      fw_allow_q, fw_allow_d;
  logic                      fw_alive_q, fw_alive_d;
  logic                      fw_link_reset_q, fw_link_reset_d;
  logic                      fw_doorbell_ring_q, fw_doorbell_ring_d;
  mbx_pkg::depth_t           fw_depth_q, fw_depth_d;
  logic [1:0]                ps_q, ps_d;
  logic                      host_rdy_q, host_rdy_d;
  logic                      fw_rdy_q, fw_rdy_d;
  mbx_pkg::word_t            h_ctl_q, h_ctl_d;
  mbx_pkg::word_t            f_csr_q, f_csr_d;
  mbx_pkg::word_t            f_view_q, f_view_d;
  logic                      alive_view_q, alive_view_d;
  logic                      d3_q, d3_d;
  logic                      fw_ring_set;
  logic                      link_fault;
  logic                      host_drop;
  logic                      host_ready_cond;
  logic                      fw_ready_cond;
  logic                      irq_cause;
  logic                      buf_clear;
  logic                      h_ovf, f_ovf;
  logic [mbx_pkg::CNT_W-1:0] h_used, f_used;
  mbx_pkg::word_t            h_rdata, f_rdata;

  db_if host_db ();
  db_if fw_db ();

  // Reset is released through two stages so that its removal is clean on clk
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_q <= 1'h0;
      rst_q      <= 1'h0;
    end
    else
    begin
      rst_meta_q <= 1'h1;
      rst_q      <= rst_meta_q;
    end
  end

  assign host_db.ring  = fw_doorbell_ring_q; // see R1
  assign host_db.clr   = host_csr_wr & host_csr_wdata[mbx_pkg::PEND_BIT]; // see R2
  assign host_db.allow = h_allow_q;
  assign fw_db.ring    = host_doorbell_ring_q;
  assign fw_db.clr     = fw_csr_wr & fw_csr_wdata[mbx_pkg::PEND_BIT];
  assign fw_db.allow   = fw_allow_q;

  mbx_doorbell u_host_db (
    .clk   (clk),
    .rst_n (rst_q),
    .ce    (ce),
    .db    (host_db.core)
  );

  mbx_doorbell u_fw_db (
    .clk   (clk),
    .rst_n (rst_q),
    .ce    (ce),
    .db    (fw_db.core)
  );

  // Either side in reset flushes both buffers; data across a reset is not trusted
  assign buf_clear = h_reset_q | fw_link_reset_q;

  mbx_cbuf u_host_cb (
    .clk      (clk),
    .rst_n    (rst_q),
    .ce       (ce),
    .clear    (buf_clear),
    .wr       (host_cb_wr),
    .wdata    (host_cb_wdata),
    .rd       (fw_cb_rd),
    .rdata    (h_rdata),
    .used     (h_used),
    .overflow (h_ovf)
  );

  mbx_cbuf u_fw_cb (
    .clk      (clk),
    .rst_n    (rst_q),
    .ce       (ce),
    .clear    (buf_clear),
    .wr       (fw_cb_wr),
    .wdata    (fw_cb_wdata),
    .rd       (fw_window_rd),
    .rdata    (f_rdata),
    .used     (f_used),
    .overflow (f_ovf)
  );

  always_comb
  begin
    h_allow_d = h_allow_q;
    h_ready_d = h_ready_q;
    h_reset_d = h_reset_q;
    if (host_csr_wr)
    begin
      h_allow_d = host_csr_wdata[mbx_pkg::ALLOW_BIT];
      h_ready_d = host_csr_wdata[mbx_pkg::READY_BIT];
      h_reset_d = host_csr_wdata[mbx_pkg::RESET_BIT];
    end
    // The ring lasts one cycle; a new ring always wins over the self-clear
    host_doorbell_ring_d = host_csr_wr & host_csr_wdata[mbx_pkg::RING_BIT];
  end

  assign host_drop  = h_ready_q & ~h_ready_d;
  assign link_fault = fw_rdy_q & (h_ovf | f_ovf | host_drop); // see R13 see R14

  always_comb
  begin
    fw_allow_d      = fw_allow_q;
    fw_alive_d      = fw_alive_q;
    fw_link_reset_d = fw_link_reset_q;
    fw_depth_d      = fw_depth_q;
    if (fw_csr_wr)
    begin
      fw_allow_d      = fw_csr_wdata[mbx_pkg::ALLOW_BIT];
      fw_alive_d      = fw_csr_wdata[mbx_pkg::READY_BIT];
      fw_link_reset_d = fw_csr_wdata[mbx_pkg::RESET_BIT];
      fw_depth_d      = fw_csr_wdata[mbx_pkg::DEPTH_LSB +: mbx_pkg::DEPTH_W];
    end
    // A detected fault overrides the reset and alive bits of a firmware write in the same cycle
    if (link_fault)
    begin
      fw_link_reset_d = 1'h1; // see R13 see R14
      fw_alive_d      = 1'h0;
    end
  end

  // Hardware rings on behalf of firmware so no change of reset or alive goes unannounced
  assign fw_ring_set = (fw_csr_wr & fw_csr_wdata[mbx_pkg::RING_BIT])
                     | fw_read_done | fw_write_done
                     | link_fault // A repeated fault still rings even when the bits already read as reset
                     | (fw_alive_d != fw_alive_q)
                     | (fw_link_reset_d != fw_link_reset_q); // see R12 see R15
  assign fw_doorbell_ring_d = fw_ring_set; // see R1

  always_comb
  begin
    ps_d = ps_q;
    // Intermediate power states are not supported and leave the state unchanged
    if ((power_state == mbx_pkg::PS_D0) || (power_state == mbx_pkg::PS_D3))
      ps_d = power_state; // see R16
    d3_d = (ps_d == mbx_pkg::PS_D3);
  end

  assign host_ready_cond = mem_space_en & (ps_q == mbx_pkg::PS_D0) & bar_assigned
                         & ~h_reset_q & h_ready_q & fw_alive_q; // see R9
  assign fw_ready_cond   = mbx_pkg::one_hot(fw_depth_q) & ~fw_link_reset_q
                         & fw_alive_q & h_ready_q; // see R10
  assign host_rdy_d      = host_ready_cond;
  assign fw_rdy_d        = fw_ready_cond;
  assign irq_cause       = host_db.pending & h_allow_q;

  always_comb
  begin
    h_ctl_d      = mbx_pkg::pack_csr(h_allow_q, host_db.pending, host_doorbell_ring_q, h_ready_q,
                                     h_reset_q, h_ovf, h_used, mbx_pkg::DEPTH_RST);
    f_csr_d      = mbx_pkg::pack_csr(fw_allow_q, fw_db.pending, fw_doorbell_ring_q, fw_alive_q,
                                     fw_link_reset_q, f_ovf, f_used, fw_depth_q);
    f_view_d     = f_csr_d;
    alive_view_d = fw_alive_q;
  end

  always_ff @(posedge clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      h_allow_q            <= 1'h0;
      h_ready_q            <= 1'h0;
      h_reset_q            <= 1'h0;
      host_doorbell_ring_q <= 1'h0;
      fw_allow_q           <= 1'h0;
      fw_alive_q           <= 1'h0;
      fw_link_reset_q      <= 1'h0;
      fw_doorbell_ring_q   <= 1'h0;
      fw_depth_q           <= mbx_pkg::DEPTH_RST;
      ps_q                 <= mbx_pkg::PS_D0;
      d3_q                 <= 1'h0;
      host_rdy_q           <= 1'h0;
      fw_rdy_q             <= 1'h0;
      h_ctl_q              <= '0;
      f_csr_q              <= '0;
      f_view_q             <= '0;
      alive_view_q         <= 1'h0;
    end
    else if (ce)
    begin
      h_allow_q            <= h_allow_d;
      h_ready_q            <= h_ready_d;
      h_reset_q            <= h_reset_d;
      host_doorbell_ring_q <= host_doorbell_ring_d;
      fw_allow_q           <= fw_allow_d;
      fw_alive_q           <= fw_alive_d;
      fw_link_reset_q      <= fw_link_reset_d;
      fw_doorbell_ring_q   <= fw_doorbell_ring_d;
      fw_depth_q           <= fw_depth_d;
      ps_q                 <= ps_d;
      d3_q                 <= d3_d;
      host_rdy_q           <= host_rdy_d;
      fw_rdy_q             <= fw_rdy_d;
      h_ctl_q              <= h_ctl_d;
      f_csr_q              <= f_csr_d;
      f_view_q             <= f_view_d;
      alive_view_q         <= alive_view_d;
    end
  end

  assign host_side_ctrl_status = h_ctl_q;
  assign fw_side_ctrl_status   = f_csr_q;
  assign fw_status_host_view   = f_view_q;
  assign fw_alive_host_view    = alive_view_q;
  assign fw_cb_rdata           = h_rdata;
  assign fw_buffer_read_window = f_rdata;
  assign fw_buffer_used_slots  = f_used;
  assign host_irq              = host_db.irq; // see R17 see R15
  assign fw_irq                = fw_db.irq;
  assign host_link_ready       = host_rdy_q;
  assign fw_link_ready         = fw_rdy_q;
  assign pm_in_d3              = d3_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_q || !ce);

  sequence fault_seen;
    link_fault;
  endsequence

  sequence reset_taken;
    fw_link_reset_q && !fw_alive_q && fw_doorbell_ring_q;
  endsequence

  ring_sets_pending_a: assert property (fw_doorbell_ring_q |=> host_db.pending) // see R1
    else $error("firmware ring did not set host pending");

  ring_self_clear_a: assert property (fw_doorbell_ring_q && !fw_ring_set |=> !fw_doorbell_ring_q) // see R1
    else $error("firmware ring did not clear itself");

  pending_clear_a: assert property (host_db.clr && !host_db.ring |=> !host_db.pending) // see R2
    else $error("host pending survived a write of one");

  irq_level_a: assert property (##1 (host_irq == $past(irq_cause))) // see R17
    else $error("host interrupt does not follow pending and allow");

  host_ready_a: assert property (##1 (host_link_ready == $past(host_ready_cond))) // see R9
    else $error("host link ready disagrees with its conditions");

  fw_ready_a: assert property (fw_link_ready |-> $past(fw_alive_q) && $past(h_ready_q)) // see R10
    else $error("firmware link ready without both sides alive");

  auto_ring_a: assert property ((fw_alive_d != fw_alive_q) || fw_read_done |=> fw_doorbell_ring_q) // see R12
    else $error("firmware state change did not ring");

  fault_reset_a: assert property (fault_seen |=> reset_taken ##1 !fw_link_ready) // see R13 see R14
    else $error("link fault did not reset the interface");

  power_legal_a: assert property ((ps_q == mbx_pkg::PS_D0) || (ps_q == mbx_pkg::PS_D3)) // see R16
    else $error("power state left D0 and D3");
endmodule
`default_nettype wire

//--- host_sw_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_sw_model (
  input  wire logic                      clk,
  input  wire mbx_pkg::word_t            host_side_ctrl_status,
  input  wire logic                      fw_alive_host_view,
  input  wire mbx_pkg::word_t            fw_status_host_view,
  input  wire logic [mbx_pkg::CNT_W-1:0] fw_buffer_used_slots,
  input  wire mbx_pkg::word_t            fw_buffer_read_window,
  output var  logic                      host_csr_wr,
  output var  mbx_pkg::word_t            host_csr_wdata,
  output var  logic                      fw_window_rd
);
  initial
  begin
    host_csr_wr    = 1'b0;
    host_csr_wdata = 32'h0;
    fw_window_rd   = 1'b0;
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Released data bus shows the inverse so a stale word never passes as fresh
  task automatic csr_write(input mbx_pkg::word_t w);
    host_csr_wr    = 1'b1;
    host_csr_wdata = w;
    tick();
    host_csr_wr    = 1'b0;
    host_csr_wdata = ~w;
    tick();
  endtask
  task automatic isr(output logic [mbx_pkg::CNT_W-1:0] n, output mbx_pkg::word_t got [8]);
    mbx_pkg::word_t s;
    n   = 4'h0;
    got = '{default: 32'h0};
    s   = host_side_ctrl_status;
    csr_write(s);
    if (fw_alive_host_view !== 1'b1) return;
    n = fw_buffer_used_slots;
    if (n == 4'h0) return;
    if (fw_status_host_view[mbx_pkg::OVF_BIT] !== 1'b0) return;
    fw_window_rd = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      tick();
      got[i] = fw_buffer_read_window;
    end
    fw_window_rd = 1'b0;
    tick();
    csr_write((s & 32'hffff_fff9) | 32'h0000_0004);
  endtask
endmodule
`default_nettype wire

//--- host_mgmt_mailbox_link_tb.sv
`timescale 1ns/10ps
`default_nettype none
module host_mgmt_mailbox_link_tb;
  typedef struct packed {logic me; logic [1:0] ps; logic bar; logic rdy; logic d3;} row_t;
  logic                      clk, rstn, ce, host_csr_wr, fw_csr_wr, mem_space_en, bar_assigned;
  logic                      host_cb_wr, fw_cb_rd, fw_cb_wr, fw_window_rd, fw_read_done, fw_write_done;
  logic                      host_irq, fw_irq, host_link_ready, fw_link_ready, pm_in_d3, fw_alive_host_view;
  logic [1:0]                power_state;
  logic [mbx_pkg::CNT_W-1:0] fw_buffer_used_slots, n;
  mbx_pkg::word_t            host_csr_wdata, host_side_ctrl_status, fw_csr_wdata, fw_side_ctrl_status;
  mbx_pkg::word_t            host_cb_wdata, fw_cb_rdata, fw_cb_wdata, fw_buffer_read_window, fw_status_host_view;
  mbx_pkg::word_t            got [8];
  int                        err_total, comparisons;
  row_t                      rows [7] = '{6'h26, 6'h04, 6'h20, 6'h3d, 6'h35, 6'h2d, 6'h26};

  host_mgmt_mailbox_link i_dut (.clk(clk), .rstn(rstn), .ce(ce), .host_csr_wr(host_csr_wr),
    .host_csr_wdata(host_csr_wdata), .host_side_ctrl_status(host_side_ctrl_status), .fw_csr_wr(fw_csr_wr),
    .fw_csr_wdata(fw_csr_wdata), .fw_side_ctrl_status(fw_side_ctrl_status), .mem_space_en(mem_space_en),
    .power_state(power_state), .bar_assigned(bar_assigned), .host_cb_wr(host_cb_wr),
    .host_cb_wdata(host_cb_wdata), .fw_cb_rd(fw_cb_rd), .fw_cb_rdata(fw_cb_rdata), .fw_cb_wr(fw_cb_wr),
    .fw_cb_wdata(fw_cb_wdata), .fw_window_rd(fw_window_rd), .fw_buffer_read_window(fw_buffer_read_window),
    .fw_buffer_used_slots(fw_buffer_used_slots), .fw_read_done(fw_read_done), .fw_write_done(fw_write_done),
    .fw_status_host_view(fw_status_host_view), .fw_alive_host_view(fw_alive_host_view), .host_irq(host_irq),
    .fw_irq(fw_irq), .host_link_ready(host_link_ready), .fw_link_ready(fw_link_ready), .pm_in_d3(pm_in_d3));

  host_sw_model i_host (.clk(clk), .host_side_ctrl_status(host_side_ctrl_status),
    .fw_alive_host_view(fw_alive_host_view), .fw_status_host_view(fw_status_host_view),
    .fw_buffer_used_slots(fw_buffer_used_slots), .fw_buffer_read_window(fw_buffer_read_window),
    .host_csr_wr(host_csr_wr), .host_csr_wdata(host_csr_wdata), .fw_window_rd(fw_window_rd));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic settle(input int k);
    repeat (k) tick();
  endtask
  task automatic chk(input mbx_pkg::word_t g, input mbx_pkg::word_t e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  function automatic mbx_pkg::word_t fw_w(input logic [7:0] depth, input logic [4:0] b);
    return {depth, 19'h0, b};
  endfunction
  task automatic fw_wr(input mbx_pkg::word_t w);
    fw_csr_wr    = 1'b1;
    fw_csr_wdata = w;
    tick();
    fw_csr_wr    = 1'b0;
    fw_csr_wdata = ~w;
    tick();
  endtask
  task automatic fw_push(input int k, input mbx_pkg::word_t base);
    fw_cb_wr = 1'b1;
    for (int i = 0; i < k; i++)
    begin
      fw_cb_wdata = base + i;
      tick();
    end
    fw_cb_wr    = 1'b0;
    fw_cb_wdata = ~base;
    tick();
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Whole sequence needs well under a thousand cycles
  initial
  begin
    #(100 * 5000);
    err_total++;
    close_out();
  end

  initial
  begin
    err_total     = 0;
    comparisons   = 0;
    rstn          = 1'b0;
    ce            = 1'b1;
    fw_csr_wr     = 1'b0;
    fw_csr_wdata  = 32'h0;
    mem_space_en  = 1'b1;
    power_state   = 2'h0;
    bar_assigned  = 1'b1;
    host_cb_wr    = 1'b0;
    host_cb_wdata = 32'h0;
    fw_cb_rd      = 1'b0;
    fw_cb_wr      = 1'b0;
    fw_cb_wdata   = 32'h0;
    fw_read_done  = 1'b0;
    fw_write_done = 1'b0;
    settle(4);
    chk(host_irq, 32'h0);
    chk(host_side_ctrl_status, 32'h0);
    rstn = 1'b1;
    settle(3);
    chk(host_side_ctrl_status, 32'h0800_0000);
    i_host.csr_write(32'h9);
    fw_wr(fw_w(8'h08, 5'h09));
    settle(4);
    chk(host_irq, 32'h1);
    chk(fw_link_ready, 32'h1);
    foreach (rows[k])
    begin
      mem_space_en = rows[k].me;
      power_state  = rows[k].ps;
      bar_assigned = rows[k].bar;
      settle(3);
      chk(host_link_ready, rows[k].rdy);
      chk(pm_in_d3, rows[k].d3);
    end
    fw_wr(fw_w(8'h0c, 5'h09));
    settle(3);
    chk(fw_link_ready, 32'h0);
    fw_wr(fw_w(8'h08, 5'h09));
    settle(3);
    chk(fw_link_ready, 32'h1);
    i_host.csr_write(32'h8);
    settle(2);
    chk(host_irq, 32'h0);
    chk(host_side_ctrl_status[1], 32'h1);
    i_host.csr_write(32'hb);
    settle(2);
    chk(host_side_ctrl_status[1], 32'h0);
    fw_wr(fw_w(8'h08, 5'h0d));
    settle(3);
    chk(host_irq, 32'h1);
    chk(fw_side_ctrl_status[2], 32'h0);
    i_host.isr(n, got);
    settle(2);
    chk(n, 32'h0);
    chk(host_irq, 32'h0);
    host_cb_wr    = 1'b1;
    host_cb_wdata = 32'hc0de_0001;
    tick();
    host_cb_wdata = 32'hc0de_0002;
    tick();
    host_cb_wr = 1'b0;
    fw_cb_rd   = 1'b1;
    tick();
    chk(fw_cb_rdata, 32'hc0de_0001);
    tick();
    chk(fw_cb_rdata, 32'hc0de_0002);
    fw_cb_rd = 1'b0;
    fw_push(3, 32'h5a5a_0010);
    fw_write_done = 1'b1;
    tick();
    fw_write_done = 1'b0;
    settle(4);
    chk(host_irq, 32'h1);
    i_host.isr(n, got);
    chk(n, 32'h3);
    for (int i = 0; i < 3; i++)
      chk(got[i], 32'h5a5a_0010 + i);
    settle(3);
    chk(fw_irq, 32'h1);
    fw_wr(fw_w(8'h08, 5'h0b));
    settle(2);
    chk(fw_irq, 32'h0);
    fw_read_done = 1'b1;
    tick();
    fw_read_done = 1'b0;
    settle(4);
    chk(host_irq, 32'h1);
    i_host.isr(n, got);
    chk(n, 32'h0);
    fw_push(9, 32'h0);
    settle(3);
    chk(fw_side_ctrl_status[4:3], 32'h2);
    chk(fw_link_ready, 32'h0);
    chk(fw_buffer_used_slots, 32'h0);
    settle(2);
    chk(fw_alive_host_view, 32'h0);
    chk(fw_status_host_view[4:3], 32'h2);
    i_host.isr(n, got);
    fw_wr(fw_w(8'h08, 5'h09));
    settle(3);
    chk(fw_link_ready, 32'h1);
    chk(host_irq, 32'h1);
    i_host.csr_write(32'h1);
    settle(3);
    chk(fw_side_ctrl_status[4], 32'h1);
    chk(fw_link_ready, 32'h0);
    // A write while frozen must be lost, not merely delayed
    ce = 1'b0;
    fw_wr(fw_w(8'h08, 5'h09));
    ce = 1'b1;
    settle(3);
    chk(fw_side_ctrl_status[4], 32'h1);
    chk(fw_link_ready, 32'h0);
    rstn = 1'b0;
    settle(2);
    chk(host_irq, 32'h0);
    chk(fw_side_ctrl_status, 32'h0);
    rstn = 1'b1;
    settle(3);
    chk(fw_side_ctrl_status, 32'h0800_0000);
    chk(fw_link_ready, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
